/* hw/asld_pkg.sv */
package asld_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 125_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYC = CLK_HZ / MS_PER_S; // cycles per millisecond
    localparam int DIV_W = 17;
    localparam int BLINK_HZ = 1;
    localparam int BLINK_PERIOD_MS = MS_PER_S / BLINK_HZ;
    localparam int BLINK_ON_MS = 500;
    localparam int STEP_MS = 250;
    localparam int FLICK_MS = 50;
    localparam int N_PORTS = 4;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CB_TEST_DONE = 0;
    localparam int CB_CONFIGURED = 1;
    localparam int CB_RECOV = 2;
    localparam int CB_UNRECOV = 3;
    localparam int CB_IP_VALID = 4;
    localparam int CB_CONN = 5;
    localparam int CB_TIMEOUT = 6;
    localparam int CB_DUP_IP = 7;
    localparam int SB_STATE = 0;  // 6 bits of sequencer state
    localparam int SB_LEDS = 8;   // module g/r, network g/r
    localparam int SB_LINK = 12;
    localparam int SB_TRAF = 16;

    // ****************************************
    // self-test sequencer
    // ****************************************
    typedef enum logic [5:0] {
        ST_MOD_GREEN = 6'b00_0001,
        ST_MOD_RED = 6'b00_0010,
        ST_NET_GREEN = 6'b00_0100,
        ST_NET_RED = 6'b00_1000,
        ST_HOLD = 6'b01_0000,
        ST_RUN = 6'b10_0000
    } asld_state_t;
endpackage

/* hw/asld_top.sv */
`timescale 1ns/1ps
module asld_top #(
    parameter int NP = asld_pkg::N_PORTS,
    parameter int MS_CYCLES = asld_pkg::MS_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // port status pins from the phys
    input wire logic [NP-1:0] link_i,
    input wire logic [NP-1:0] frame_toggle_i,
    // indicators
    output logic module_health_indicator_green_o,
    output logic module_health_indicator_red_o,
    output logic network_health_indicator_green_o,
    output logic network_health_indicator_red_o,
    output logic [NP-1:0] link_indicator_o,
    output logic [NP-1:0] traffic_indicator_o
);
    import asld_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [9:0] ms;
        logic [7:0] step;
        asld_state_t st;
        logic [7:0] ctrl;
        logic [31:0] rdata;
        logic [NP-1:0] lk_s1;
        logic [NP-1:0] lk_s2;
        logic [NP-1:0] lk_s3;
        logic [NP-1:0] lk_f;
        logic [NP-1:0] fr_s1;
        logic [NP-1:0] fr_s2;
        logic [NP-1:0] fr_s3;
        logic [NP-1:0] fr_f;
        logic [NP-1:0] tr_on;
        logic [NP-1:0] tr_busy;
        logic [NP-1:0] tr_pend;
        logic [NP-1:0][5:0] tr_cnt;
        logic msg;
        logic msr;
        logic nsg;
        logic nsr;
        logic [NP-1:0] lk_led;
        logic [NP-1:0] tr_led;
    } asld_reg_t;

    asld_reg_t r;
    asld_reg_t next_r;

    logic ms_tick;
    logic blink;
    logic step_end;
    logic wr_ctrl;
    logic addr_ok;

    // step a millisecond counter down, saturating at zero
    function automatic logic [5:0] dn6(input logic [5:0] v);
        return (v == 6'h00) ? 6'h00 : v - 6'h01;
    endfunction

    // ****************************************
    // apb handshake
    // ****************************************
    // zero wait states; unmapped addresses answer with an error
    assign addr_ok = (paddr_i == CTRL_OFF) || (paddr_i == STATUS_OFF);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_ok;
    assign wr_ctrl = psel_i & penable_i & pwrite_i & (paddr_i == CTRL_OFF) & pstrb_i[0];

    // ****************************************
    // time base
    // ****************************************
    // one shared millisecond counter keeps all 1 hz patterns in phase
    assign ms_tick = (r.div == DIV_W'(MS_CYCLES - 1));
    assign blink = (r.ms < 10'(BLINK_ON_MS));
    assign step_end = ms_tick && (r.step == 8'(STEP_MS - 1));

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_r = r;

        // millisecond divider and 1 s cycle
        next_r.div = ms_tick ? '0 : r.div + DIV_W'(1);
        if (ms_tick) begin
            next_r.ms = (r.ms == 10'(BLINK_PERIOD_MS - 1)) ? 10'h000 : r.ms + 10'h001;
        end

        // register writes take effect at the access edge only
        if (wr_ctrl) begin
            next_r.ctrl = pwdata_i[7:0];
        end

        // read data captured in the setup phase, stable in access
        if (psel_i && !penable_i) begin
            next_r.rdata = 32'h0000_0000;
            if (paddr_i == CTRL_OFF) begin
                next_r.rdata[7:0] = r.ctrl;
            end else if (paddr_i == STATUS_OFF) begin
                next_r.rdata[SB_STATE +: 6] = r.st;
                next_r.rdata[SB_LEDS +: 4] = {r.nsr, r.nsg, r.msr, r.msg};
                next_r.rdata[SB_LINK +: 4] = 4'(r.lk_f);
                next_r.rdata[SB_TRAF +: 4] = 4'(r.tr_led);
            end
        end

        // self-test sequencer: module steps run before network steps
        if (r.st != ST_HOLD && r.st != ST_RUN) begin
            next_r.step = ms_tick ? (step_end ? 8'h00 : r.step + 8'h01) : r.step;
        end
        case (r.st)
            ST_MOD_GREEN: begin
                if (step_end) begin
                    next_r.st = ST_MOD_RED;
                end
            end
            ST_MOD_RED: begin
                if (step_end) begin
                    next_r.st = ST_NET_GREEN;
                end
            end
            ST_NET_GREEN: begin
                if (step_end) begin
                    next_r.st = ST_NET_RED;
                end
            end
            ST_NET_RED: begin
                if (step_end) begin
                    next_r.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // a done flag written early waits for the sequence
                if (r.ctrl[CB_TEST_DONE]) begin
                    next_r.st = ST_RUN;
                end
            end
            ST_RUN: begin
                next_r.st = ST_RUN;
            end
            default: begin
                next_r.st = ST_MOD_GREEN;
            end
        endcase

        // module indicator
        case (r.st)
            ST_MOD_GREEN, ST_NET_GREEN, ST_NET_RED, ST_HOLD: begin
                next_r.msg = 1'b1;
                next_r.msr = 1'b0;
            end
            ST_MOD_RED: begin
                next_r.msg = 1'b0;
                next_r.msr = 1'b1;
            end
            default: begin
                if (r.ctrl[CB_UNRECOV]) begin
                    next_r.msg = 1'b0;
                    next_r.msr = 1'b1;
                end else if (r.ctrl[CB_RECOV]) begin
                    next_r.msg = 1'b0;
                    next_r.msr = blink;
                end else if (!r.ctrl[CB_CONFIGURED]) begin
                    next_r.msg = blink;
                    next_r.msr = 1'b0;
                end else begin
                    next_r.msg = 1'b1;
                    next_r.msr = 1'b0;
                end
            end
        endcase

        // network indicator, in fixed priority order
        case (r.st)
            ST_NET_GREEN: begin
                next_r.nsg = 1'b1;
                next_r.nsr = 1'b0;
            end
            ST_NET_RED: begin
                next_r.nsg = 1'b0;
                next_r.nsr = 1'b1;
            end
            ST_RUN: begin
                next_r.nsg = 1'b0;
                next_r.nsr = 1'b0;
                if (!r.ctrl[CB_IP_VALID]) begin
                    next_r.nsr = 1'b0;
                end else if (r.ctrl[CB_DUP_IP]) begin
                    next_r.nsr = 1'b1;
                end else if (r.ctrl[CB_TIMEOUT]) begin
                    // flashes red until the stack clears every timeout
                    next_r.nsr = blink;
                end else if (r.ctrl[CB_CONN]) begin
                    next_r.nsg = 1'b1;
                end else begin
                    next_r.nsg = blink;
                end
            end
            default: begin
                // dark while the module part of the test runs and in hold
                next_r.nsg = 1'b0;
                next_r.nsr = 1'b0;
            end
        endcase

        // pin synchronisers; a change counts once stages two and three agree
        next_r.lk_s1 = link_i;
        next_r.lk_s2 = r.lk_s1;
        next_r.lk_s3 = r.lk_s2;
        next_r.fr_s1 = frame_toggle_i;
        next_r.fr_s2 = r.fr_s1;
        next_r.fr_s3 = r.fr_s2;
        for (int i = 0; i < NP; i++) begin
            if (r.lk_s2[i] == r.lk_s3[i]) begin
                next_r.lk_f[i] = r.lk_s2[i];
            end
            if (r.fr_s2[i] == r.fr_s3[i]) begin
                next_r.fr_f[i] = r.fr_s2[i];
            end
        end
        next_r.lk_led = r.lk_f;

        // traffic flicker: on phase, off phase, then idle
        // the countdown runs even in a frame cycle, or busy traffic would stretch the phases
        for (int i = 0; i < NP; i++) begin
            if (r.tr_busy[i] && ms_tick) begin
                next_r.tr_cnt[i] = dn6(r.tr_cnt[i]);
                if (r.tr_cnt[i] == 6'h01) begin
                    if (r.tr_on[i]) begin
                        next_r.tr_on[i] = 1'b0;
                        next_r.tr_cnt[i] = 6'(FLICK_MS);
                    end else if (r.tr_pend[i]) begin
                        next_r.tr_on[i] = 1'b1;
                        next_r.tr_pend[i] = 1'b0;
                        next_r.tr_cnt[i] = 6'(FLICK_MS);
                    end else begin
                        next_r.tr_busy[i] = 1'b0;
                    end
                end
            end
            // a frame seen during a running flicker is kept for the next one;
            // one that meets the end of a flicker starts a fresh one (set wins)
            if ((r.fr_s2[i] == r.fr_s3[i]) && (r.fr_s2[i] != r.fr_f[i])) begin
                if (!next_r.tr_busy[i]) begin
                    next_r.tr_busy[i] = 1'b1;
                    next_r.tr_on[i] = 1'b1;
                    next_r.tr_cnt[i] = 6'(FLICK_MS);
                end else begin
                    next_r.tr_pend[i] = 1'b1;
                end
            end
        end
        next_r.tr_led = r.tr_on;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
            r.st <= ST_MOD_GREEN;
            r.ctrl <= CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata_o = r.rdata;
    assign module_health_indicator_green_o = r.msg;
    assign module_health_indicator_red_o = r.msr;
    assign network_health_indicator_green_o = r.nsg;
    assign network_health_indicator_red_o = r.nsr;
    assign link_indicator_o = r.lk_led;
    assign traffic_indicator_o = r.tr_led;
endmodule // asld_top

/* testbench/adapter_status_led_driver_tb.sv */
`timescale 1ns/1ps
module adapter_status_led_driver_tb;
    import asld_pkg::*;
    // ****
    // bench signals
    // ****
    localparam int M = 10;  // short ms tick keeps the run small
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [3:0] pstrb_i = 4'hf;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [N_PORTS-1:0] link_i = '0;
    logic [N_PORTS-1:0] frame_toggle_i = '0;
    logic module_health_indicator_green_o;
    logic module_health_indicator_red_o;
    logic network_health_indicator_green_o;
    logic network_health_indicator_red_o;
    logic [N_PORTS-1:0] link_indicator_o;
    logic [N_PORTS-1:0] traffic_indicator_o;
    logic [3:0] leds;
    logic [7:0][31:0] on_len;
    logic [7:0][31:0] off_len;
    logic [31:0] q;
    logic e;
    logic [15:0] lfsr = 16'h0033;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int p;
    logic [3:0] st_exp [5] = '{4'h1, 4'h2, 4'h5, 4'h9, 4'h1};
    logic [7:0] md [6] = '{8'h03, 8'h0b, 8'h33, 8'hb3, 8'hf3, 8'h33};
    logic [3:0] md_exp [6] = '{4'h1, 4'h2, 4'h5, 4'h9, 4'h9, 4'h5};
    assign leds = {network_health_indicator_red_o, network_health_indicator_green_o,
        module_health_indicator_red_o, module_health_indicator_green_o};
    asld_top #(.MS_CYCLES(M)) i_dut (.*);
    asld_viewer #(.W(8)) i_view (.clk_i(clk_i), .rst_i(reset_i),
        .led_i({traffic_indicator_o, leds}), .on_len_o(on_len), .off_len_o(off_len));
    // ****
    // helpers
    // ****
    function automatic logic [15:0] next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // a flicker cut by a partial first tick may lose up to one ms
    function automatic logic [31:0] near50(input logic [31:0] v);
        return 32'(v >= 49 * M && v <= 50 * M);
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****
    // clock, hang guard and scenarios
    // ****
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            report_and_stop;
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            repeat ((i == 0 ? 125 : 250) * M) @(posedge clk_i);
            check("test lamps", 32'(leds), 32'(st_exp[i]));
        end
        for (int i = 0; i < 6; i++) begin
            lfsr = next(lfsr);
            link_i <= lfsr[3:0];
            repeat (8) @(posedge clk_i);
            check("link lamps", 32'(link_indicator_o), 32'(lfsr[3:0]));
        end
        apb(1'b1, 12'h000, 32'hffff_ff5a);
        apb(1'b1, 12'h004, 32'hffff_ffff);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check("held state", 32'(q[5:0]), 32'h0000_0010);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check("control", q, 32'h0000_005a);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check("unmapped", {q[30:0], e}, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h000, 32'(md[i]));
            repeat (10) @(posedge clk_i);
            check("steady lamps", 32'(leds), 32'(md_exp[i]));
        end
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, 12'h000, j == 0 ? 32'h0000_0011 : 32'h0000_0057);
            repeat (2100 * M) @(posedge clk_i);
            check("same phase", 32'(leds[j]), 32'(leds[j+2]));
            for (int k = j; k < 4; k += 2) begin
                check("blink on", on_len[k], 32'(500 * M));
                check("blink off", off_len[k], 32'(500 * M));
            end
        end
        apb(1'b1, 12'h000, 32'h0000_0073);
        repeat (10) @(posedge clk_i);
        check("timeout green", 32'(leds[2]), 32'h0000_0000);
        apb(1'b1, 12'h000, 32'h0000_0033);
        repeat (10) @(posedge clk_i);
        check("timeout cleared", 32'(leds), 32'h0000_0005);
        lfsr = next(lfsr);
        p = int'(lfsr[1:0]);
        frame_toggle_i[p] <= ~frame_toggle_i[p];
        repeat (8) @(posedge clk_i);
        check("one frame", 32'(traffic_indicator_o[p]), 32'h0000_0001);
        repeat (120 * M) @(posedge clk_i);
        check("stretch", near50(on_len[4+p]), 32'h0000_0001);
        for (int i = 0; i < 150; i++) begin
            frame_toggle_i[p] <= ~frame_toggle_i[p];
            repeat (20) @(posedge clk_i);
        end
        check("busy on", near50(on_len[4+p]), 32'h0000_0001);
        check("busy off", near50(off_len[4+p]), 32'h0000_0001);
        repeat (200 * M) @(posedge clk_i);
        check("quiet", 32'(traffic_indicator_o), 32'h0000_0000);
        report_and_stop;
    end
endmodule // adapter_status_led_driver_tb

/* testbench/asld_chk.sv */
`timescale 1ns/1ps
// ****
// port checker
// ****
module asld_chk #(
    parameter int NP = 4,
    parameter int MS_CYCLES = 10
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic pslverr_o,
    // port pins and lamps
    input wire logic [NP-1:0] link_i,
    input wire logic [NP-1:0] frame_toggle_i,
    input wire logic module_health_indicator_green_o,
    input wire logic module_health_indicator_red_o,
    input wire logic network_health_indicator_green_o,
    input wire logic network_health_indicator_red_o,
    input wire logic [NP-1:0] link_indicator_o,
    input wire logic [NP-1:0] traffic_indicator_o
);
    localparam int M = MS_CYCLES;
    logic [7:0] ctl;
    logic [31:0] age;
    logic [31:0] idle;
    logic [2:0] calm;
    logic acc;
    logic run;
    logic [3:0] leds;
    assign acc = psel_i && penable_i;
    assign run = ctl[0] && age > 1010 * M && calm > 3'd4;
    assign leds = {network_health_indicator_red_o, network_health_indicator_green_o,
        module_health_indicator_red_o, module_health_indicator_green_o};
    // shadow of the control byte; run-state lamps are judged only once writes have settled
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctl <= 8'h00;
            age <= '0;
            idle <= '0;
            calm <= '0;
        end else begin
            if (acc && pwrite_i && paddr_i == 12'h000 && pstrb_i[0]) ctl <= pwdata_i[7:0];
            age <= age + 32'd1;
            idle <= $changed(frame_toggle_i) ? 32'd0 : idle + 32'd1;
            calm <= (acc && pwrite_i) ? 3'd0 : calm + {2'd0, calm != 3'd7};
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence link_quiet;
        $stable(link_i) [*8];
    endsequence
    bad_addr_a: assert property (acc && paddr_i != 12'h000 && paddr_i != 12'h004 |-> pslverr_o)
        else $error("no error on unmapped address");
    test_one_a: assert property (age > 5 && age < 240 * M |-> leds == 4'h1)
        else $error("first test step wrong");
    test_two_a: assert property (age > 260 * M && age < 490 * M |-> leds == 4'h2)
        else $error("second test step wrong");
    test_three_a: assert property (age > 510 * M && age < 740 * M |-> leds == 4'h5)
        else $error("third test step wrong");
    test_four_a: assert property (age > 760 * M && age < 990 * M |-> leds == 4'h9)
        else $error("fourth test step wrong");
    hold_lamps_a: assert property (age > 1010 * M && !ctl[0] |-> leds == 4'h1)
        else $error("held lamps wrong");
    net_dark_a: assert property (run && !ctl[4] |-> leds[3:2] == 2'b00)
        else $error("network lit without address");
    dup_red_a: assert property (run && ctl[4] && ctl[7] |-> leds[3:2] == 2'b10)
        else $error("duplicate address not red");
    conn_green_a: assert property (run && ctl[7:4] == 4'h3 |-> leds[3:2] == 2'b01)
        else $error("connected not green");
    fatal_red_a: assert property (run && ctl[3] |-> leds[1:0] == 2'b10)
        else $error("unrecoverable fault not red");
    link_follow_a: assert property (link_quiet |-> link_indicator_o == link_i)
        else $error("link lamp differs from link");
    traf_idle_a: assert property (idle > 160 * M |-> traffic_indicator_o == '0)
        else $error("traffic lamp lit without frames");
endmodule // asld_chk

bind asld_top asld_chk #(.NP(NP), .MS_CYCLES(MS_CYCLES)) i_chk (.*);

/* testbench/asld_viewer.sv */
`timescale 1ns/1ps
// ****
// operator view: length of the last whole lit and dark spell of each lamp
// ****
module asld_viewer #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // lamps and measured spells in cycles
    input wire logic [W-1:0] led_i,
    output logic [W-1:0][31:0] on_len_o,
    output logic [W-1:0][31:0] off_len_o
);
    logic [W-1:0][31:0] run_len;
    logic [W-1:0] last;
    // a spell is stored only when it ends, so a cut spell never shows
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < W; i++) begin
            run_len[i] <= (led_i[i] != last[i] || rst_i) ? 32'd1 : run_len[i] + 32'd1;
            if (led_i[i] && !last[i]) off_len_o[i] <= run_len[i];
            if (!led_i[i] && last[i]) on_len_o[i] <= run_len[i];
        end
        last <= rst_i ? '0 : led_i;
    end
endmodule // asld_viewer
